// File: core/dcbo_consts.vh
// Purpose: shared constants for the dc block and overrange flag block
// Assumes: 24-bit signed samples, 100 MHz system clock
// Notes: all offsets and fields live here, plus the ctrl reset and master clock counts
`ifndef DCBO_CONSTS_VH
`define DCBO_CONSTS_VH
`define DCBO_SW 24
`define DCBO_ACC_W 40
`define DCBO_SHIFT 16
`define DCBO_POS_FS 24'h7FFFFF
`define DCBO_NEG_FS 24'h800000
`define DCBO_ADDR_W 3
`define DCBO_REG_CTRL 3'h0
`define DCBO_REG_STAT 3'h1
`define DCBO_REG_MASK 3'h2
`define DCBO_REG_TOUT 3'h3
`define DCBO_REG_DCL 3'h4
`define DCBO_REG_DCR 3'h5
`define DCBO_CTRL_HOLD 0
`define DCBO_CTRL_I2S 1
`define DCBO_CTRL_MASTER 2
`define DCBO_CTRL_MODE_LO 3
`define DCBO_CTRL_RST 32'h0000_0000
`define DCBO_STAT_OVL 0
`define DCBO_STAT_OVR 1
`define DCBO_STAT_W 2
`define DCBO_MODE_SS 2'h0
`define DCBO_MODE_DS 2'h1
`define DCBO_MODE_QS 2'h2
`define DCBO_TOUT_W 24
`define DCBO_DLY_LJ 2'h1
`define DCBO_DLY_I2S 2'h2
`define DCBO_MDIV_W 8
`define DCBO_MDIV_HALF 8'h04
`define DCBO_BPF_HALF 5'h1F
`endif

// File: core/dcbo_dc_filter.v
// Purpose: one-channel dc removal with estimate hold
// Assumes: sample strobe from the same clock domain
// Notes: leaky integrator estimate, corner set by DCBO_SHIFT
`timescale 1ns/100ps
`include "dcbo_consts.vh"
module dcbo_dc_filter (
  input wire clk_i, // system clock
  input wire rst_n_i, // async reset, active low
  input wire stb_i, // new decimated sample
  input wire hold_i, // freeze the estimate
  input wire [`DCBO_SW-1:0] din_i, // decimated sample
  output reg [`DCBO_SW-1:0] dout_o, // dc-removed sample
  output reg stb_o, // output strobe
  output wire [`DCBO_SW-1:0] est_o // current estimate
);
  reg signed [`DCBO_ACC_W-1:0] acc_q;
  wire signed [`DCBO_SW:0] diff;
  wire signed [`DCBO_SW-1:0] est;
  assign est = acc_q[`DCBO_ACC_W-1:`DCBO_SHIFT];
  assign est_o = est;
  assign diff = $signed({din_i[`DCBO_SW-1], din_i}) - $signed({est[`DCBO_SW-1], est});
  // saturate so a full-scale sample stays at full scale and can be flagged
  function [`DCBO_SW-1:0] sat;
    input [`DCBO_SW:0] v;
    begin
      if (v[`DCBO_SW] != v[`DCBO_SW-1])
        sat = v[`DCBO_SW] ? `DCBO_NEG_FS : `DCBO_POS_FS;
      else
        sat = v[`DCBO_SW-1:0];
    end
  endfunction
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= {`DCBO_ACC_W{1'b0}};
      dout_o <= {`DCBO_SW{1'b0}};
      stb_o <= 1'b0;
    end else begin
      stb_o <= stb_i;
      if (stb_i) begin
        dout_o <= sat(diff);
        if (!hold_i)
          acc_q <= acc_q + {{(`DCBO_ACC_W-`DCBO_SW-1){diff[`DCBO_SW]}}, diff};
      end
    end
  end
endmodule // dcbo_dc_filter

// File: core/dcbo_top.v
// Purpose: dc block stage plus multiplexed open-drain overrange flag
// Assumes: frame and bit clocks slower than clk_i; avalon-mm slave
// Notes: overrange flags are held until the hold-off timeout expires
`timescale 1ns/100ps
`include "dcbo_consts.vh"
// Contract
// - subtract a running dc estimate from every decimated sample
// - while hold is high the estimate freezes but is still subtracted
// - per-channel overrange flags multiplexed on one active-low open-drain pin
// - flag goes low at the next update point after detection
// - flags return high after timeout with no further overrange
// - overrange on either channel restarts timeout for both
// - pin released when no overflow, driven low when one exists
// - left-justified: pin updates one bit clock after frame edge
// - i2s: pin updates two bit clocks after frame edge
// - master mode makes frame clock at fs and bit clock at 64 fs
module dcbo_top #(
  parameter [`DCBO_TOUT_W-1:0] TOUT_SS = 24'h0186A0, // hold-off cycles, single speed
  parameter [`DCBO_TOUT_W-1:0] TOUT_DS = 24'h00C350, // hold-off cycles, double speed
  parameter [`DCBO_TOUT_W-1:0] TOUT_QS = 24'h0061A8 // hold-off cycles, quad speed
) (
  input wire clk_i, // system clock 100 MHz
  input wire rst_n_i, // async reset, active low
  input wire [`DCBO_ADDR_W-1:0] avs_address_i, // word address
  input wire avs_read_i, // read request
  input wire avs_write_i, // write request
  input wire [31:0] avs_writedata_i, // write data
  output reg [31:0] avs_readdata_o, // read data
  output reg avs_waitrequest_o, // stall
  input wire dc_block_hold_i, // hold pin, or-ed with ctrl bit
  input wire smp_stb_i, // decimated sample pair strobe
  input wire [`DCBO_SW-1:0] smp_l_i, // left sample
  input wire [`DCBO_SW-1:0] smp_r_i, // right sample
  output reg out_stb_o, // filtered pair strobe
  output reg [`DCBO_SW-1:0] out_l_o, // filtered left
  output reg [`DCBO_SW-1:0] out_r_o, // filtered right
  input wire frame_clock_i, // frame clock in slave mode
  input wire bit_clock_i, // bit clock in slave mode
  output reg frame_clock_o, // frame clock in master mode
  output reg bit_clock_o, // bit clock in master mode
  output reg clocks_oe_o, // drive serial clocks (master mode)
  output reg ovfl_n_o, // overrange pin output value
  output reg ovfl_oe_o, // overrange pin enable, high drives low
  output reg irq_o // interrupt, level
);
  reg [31:0] ctrl_q;
  reg [`DCBO_STAT_W-1:0] stat_q, mask_q;
  reg hold_s1_q, hold_s2_q, fc_s1_q, fc_s2_q, fc_s3_q, bc_s1_q, bc_s2_q, bc_s3_q;
  reg [`DCBO_TOUT_W-1:0] tout_q;
  reg flag_l_q, flag_r_q;
  reg [1:0] dly_q;
  reg pend_q;
  reg [`DCBO_MDIV_W-1:0] mdiv_q;
  reg [5:0] bcnt_q;
  wire hold, master, i2s, fc, fc_edge, bc_rise, l_stb, r_stb, ov_l, ov_r, ov_any;
  wire [1:0] mode;
  wire [`DCBO_SW-1:0] fl, fr, est_l, est_r;
  wire [`DCBO_STAT_W-1:0] stat_set;
  reg [`DCBO_TOUT_W-1:0] tout_len;
  reg [31:0] rd_mux;

  assign master = ctrl_q[`DCBO_CTRL_MASTER];
  assign i2s = ctrl_q[`DCBO_CTRL_I2S];
  assign mode = ctrl_q[`DCBO_CTRL_MODE_LO+1:`DCBO_CTRL_MODE_LO];
  assign hold = hold_s2_q | ctrl_q[`DCBO_CTRL_HOLD];

  dcbo_dc_filter u_fl (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .stb_i(smp_stb_i),
    .hold_i(hold),
    .din_i(smp_l_i),
    .dout_o(fl),
    .stb_o(l_stb),
    .est_o(est_l)
  );
  dcbo_dc_filter u_fr (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .stb_i(smp_stb_i),
    .hold_i(hold),
    .din_i(smp_r_i),
    .dout_o(fr),
    .stb_o(r_stb),
    .est_o(est_r)
  );

  function is_fs;
    input [`DCBO_SW-1:0] s;
    begin
      is_fs = (s == `DCBO_POS_FS) || (s == `DCBO_NEG_FS);
    end
  endfunction
  assign ov_l = l_stb & is_fs(fl);
  assign ov_r = r_stb & is_fs(fr);
  assign ov_any = ov_l | ov_r;
  assign stat_set = {ov_r, ov_l};

  always @* begin
    case (mode)
      `DCBO_MODE_SS: tout_len = TOUT_SS;
      `DCBO_MODE_DS: tout_len = TOUT_DS;
      `DCBO_MODE_QS: tout_len = TOUT_QS;
      default: tout_len = TOUT_SS;
    endcase
  end

  // frame/bit clock source: own divider in master mode, synchronised pins otherwise
  assign fc = master ? frame_clock_o : fc_s2_q;
  // in master mode the frame clock toggles on the bit rise that ends each 32-bit half
  assign fc_edge = master ? (bc_rise && bcnt_q[4:0] == `DCBO_BPF_HALF) : (fc_s2_q ^ fc_s3_q);
  assign bc_rise = master ? (mdiv_q == `DCBO_MDIV_HALF - 8'h01 && !bit_clock_o)
                          : (bc_s2_q & ~bc_s3_q);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_s1_q <= 1'b0;
      hold_s2_q <= 1'b0;
      fc_s1_q <= 1'b0;
      fc_s2_q <= 1'b0;
      fc_s3_q <= 1'b0;
      bc_s1_q <= 1'b0;
      bc_s2_q <= 1'b0;
      bc_s3_q <= 1'b0;
    end else begin
      hold_s1_q <= dc_block_hold_i;
      hold_s2_q <= hold_s1_q;
      fc_s1_q <= frame_clock_i;
      fc_s2_q <= fc_s1_q;
      fc_s3_q <= fc_s2_q;
      bc_s1_q <= bit_clock_i;
      bc_s2_q <= bc_s1_q;
      bc_s3_q <= bc_s2_q;
    end
  end

  // master clock generation: bit clock = clk/(2*half), frame = bit/64
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mdiv_q <= {`DCBO_MDIV_W{1'b0}};
      bcnt_q <= 6'h00;
      bit_clock_o <= 1'b0;
      frame_clock_o <= 1'b0;
      clocks_oe_o <= 1'b0;
    end else begin
      clocks_oe_o <= master;
      if (!master) begin
        mdiv_q <= {`DCBO_MDIV_W{1'b0}};
        bcnt_q <= 6'h00;
        bit_clock_o <= 1'b0;
        frame_clock_o <= 1'b0;
      end else if (mdiv_q == `DCBO_MDIV_HALF - 8'h01) begin
        mdiv_q <= {`DCBO_MDIV_W{1'b0}};
        bit_clock_o <= ~bit_clock_o;
        if (!bit_clock_o) begin
          bcnt_q <= bcnt_q + 6'h01;
          if (bcnt_q[4:0] == `DCBO_BPF_HALF)
            frame_clock_o <= ~frame_clock_o;
        end
      end else begin
        mdiv_q <= mdiv_q + 8'h01;
      end
    end
  end

  // hold-off flags and pin update timing
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_l_q <= 1'b0;
      flag_r_q <= 1'b0;
      tout_q <= {`DCBO_TOUT_W{1'b0}};
      dly_q <= 2'h0;
      pend_q <= 1'b0;
      ovfl_n_o <= 1'b1;
      ovfl_oe_o <= 1'b0;
    end else begin
      if (ov_any) begin
        tout_q <= tout_len;
        if (ov_l)
          flag_l_q <= 1'b1;
        if (ov_r)
          flag_r_q <= 1'b1;
      end else if (tout_q != {`DCBO_TOUT_W{1'b0}}) begin
        tout_q <= tout_q - {{(`DCBO_TOUT_W-1){1'b0}}, 1'b1};
      end else begin
        flag_l_q <= 1'b0;
        flag_r_q <= 1'b0;
      end
      if (fc_edge) begin
        pend_q <= 1'b1;
        dly_q <= i2s ? `DCBO_DLY_I2S : `DCBO_DLY_LJ;
      end else if (pend_q && bc_rise) begin
        if (dly_q == 2'h1) begin
          pend_q <= 1'b0;
          // lj: high frame = left slot, flag latched on falling edge; i2s reversed
          if (fc ^ i2s) begin
            ovfl_oe_o <= flag_l_q;
            ovfl_n_o <= ~flag_l_q;
          end else begin
            ovfl_oe_o <= flag_r_q;
            ovfl_n_o <= ~flag_r_q;
          end
        end
        dly_q <= dly_q - 2'h1;
      end
    end
  end

  // avalon slave: one wait cycle on every access, then answer
  always @* begin
    case (avs_address_i)
      `DCBO_REG_CTRL: rd_mux = ctrl_q;
      `DCBO_REG_STAT: rd_mux = {{(32-`DCBO_STAT_W){1'b0}}, stat_q};
      `DCBO_REG_MASK: rd_mux = {{(32-`DCBO_STAT_W){1'b0}}, mask_q};
      `DCBO_REG_TOUT: rd_mux = {{(32-`DCBO_TOUT_W){1'b0}}, tout_q};
      `DCBO_REG_DCL: rd_mux = {{(32-`DCBO_SW){est_l[`DCBO_SW-1]}}, est_l};
      `DCBO_REG_DCR: rd_mux = {{(32-`DCBO_SW){est_r[`DCBO_SW-1]}}, est_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `DCBO_CTRL_RST;
      stat_q <= {`DCBO_STAT_W{1'b0}};
      mask_q <= {`DCBO_STAT_W{1'b0}};
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      irq_o <= 1'b0;
      out_stb_o <= 1'b0;
      out_l_o <= {`DCBO_SW{1'b0}};
      out_r_o <= {`DCBO_SW{1'b0}};
    end else begin
      out_stb_o <= l_stb;
      if (l_stb) begin
        out_l_o <= fl;
        out_r_o <= fr;
      end
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      if ((avs_read_i | avs_write_i) && avs_waitrequest_o) begin
        avs_readdata_o <= avs_read_i ? rd_mux : 32'h0000_0000;
      end
      // writes land at the answering edge, where waitrequest is low; set wins over clear
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == `DCBO_REG_STAT)
        stat_q <= (stat_q & ~avs_writedata_i[`DCBO_STAT_W-1:0]) | stat_set;
      else
        stat_q <= stat_q | stat_set;
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == `DCBO_REG_CTRL)
        ctrl_q <= {27'h0, avs_writedata_i[4:0]};
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == `DCBO_REG_MASK)
        mask_q <= avs_writedata_i[`DCBO_STAT_W-1:0];
      irq_o <= |(stat_q & mask_q);
    end
  end
endmodule // dcbo_top

// File: verification/dcbo_props.sv
// Purpose: port assertions for dcbo_top
// Assumes: slave frame of about 800 clocks
// Notes: bound to every dcbo_top
`timescale 1ns/100ps
`include "dcbo_consts.vh"
module dcbo_props #(
  parameter [`DCBO_TOUT_W-1:0] TOUT_SS = 24'h0186A0
) (
  input wire clk_i, // clock
  input wire rst_n_i, // reset
  input wire avs_read_i, // read
  input wire avs_write_i, // write
  input wire avs_waitrequest_o, // stall
  input wire smp_stb_i, // sample in
  input wire out_stb_o, // sample out
  input wire [`DCBO_SW-1:0] out_l_o, // left
  input wire [`DCBO_SW-1:0] out_r_o, // right
  input wire frame_clock_o, // frame
  input wire bit_clock_o, // bit
  input wire clocks_oe_o, // drive
  input wire ovfl_n_o, // pin
  input wire ovfl_oe_o // enable
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire sat = out_stb_o && (out_l_o == `DCBO_NEG_FS || out_l_o == `DCBO_POS_FS ||
    out_r_o == `DCBO_NEG_FS || out_r_o == `DCBO_POS_FS);
  reg [31:0] quiet_q;
  // saturating, so a long idle run never wraps back into the window
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) quiet_q <= 32'h0;
    else if (sat) quiet_q <= 32'h0;
    else if (quiet_q != 32'hFFFFFFFF) quiet_q <= quiet_q + 32'h1;
  end
  req_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o) else $error("bus request not answered");
  wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  stb_lat_a: assert property (smp_stb_i |-> ##2 out_stb_o)
    else $error("filtered strobe late");
  sat_flag_a: assert property (sat |-> ##[1:1000] ovfl_oe_o)
    else $error("overrange not flagged");
  pin_level_a: assert property (ovfl_oe_o == !ovfl_n_o)
    else $error("pin value and enable disagree");
  hold_off_a: assert property (quiet_q > TOUT_SS + 32'h7D0 |-> !ovfl_oe_o)
    else $error("flag outlived hold-off");
  clk_idle_a: assert property (!clocks_oe_o [*2] |-> !bit_clock_o && !frame_clock_o)
    else $error("serial clocks run in slave mode");
  bit_half_a: assert property ($rose(bit_clock_o) |-> bit_clock_o [*4] ##1 !bit_clock_o)
    else $error("bit clock half period wrong");
  frame_hold_a: assert property ($changed(frame_clock_o) |=> $stable(frame_clock_o) [*8])
    else $error("frame clock toggles too fast");
  cover property (sat);
  cover property ($rose(ovfl_oe_o));
  cover property ($rose(clocks_oe_o));
endmodule // dcbo_props
bind dcbo_top dcbo_props #(.TOUT_SS(TOUT_SS)) u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .smp_stb_i(smp_stb_i), .out_stb_o(out_stb_o), .out_l_o(out_l_o), .out_r_o(out_r_o),
  .frame_clock_o(frame_clock_o), .bit_clock_o(bit_clock_o), .clocks_oe_o(clocks_oe_o),
  .ovfl_n_o(ovfl_n_o), .ovfl_oe_o(ovfl_oe_o));

// File: verification/dcbo_host.sv
// Purpose: receiving controller, clock master of the serial link
// Assumes: 64 bit clocks per frame, bit period 125 ns
// Notes: flags are latched active high
`timescale 1ns/100ps
module dcbo_host (
  input wire i2s_i, // i2s format
  input wire pin_i, // resolved line
  output reg bit_clock_o, // bit clock
  output reg frame_clock_o, // frame clock
  output reg flag_l_o, // left overrange
  output reg flag_r_o // right overrange
);
  integer n;
  initial begin
    bit_clock_o = 1'b0;
    frame_clock_o = 1'b0;
    flag_l_o = 1'b0;
    flag_r_o = 1'b0;
    n = 0;
    forever #62.5 bit_clock_o = ~bit_clock_o;
  end
  always @(negedge bit_clock_o) begin
    n <= (n + 1) % 32;
    if (n == 31) frame_clock_o <= ~frame_clock_o;
  end
  // the line still shows the half that just ended
  always @(posedge frame_clock_o) begin
    if (i2s_i) flag_l_o <= ~pin_i;
    else flag_r_o <= ~pin_i;
  end
  always @(negedge frame_clock_o) begin
    if (i2s_i) flag_r_o <= ~pin_i;
    else flag_l_o <= ~pin_i;
  end
endmodule // dcbo_host

// File: verification/tb.sv
// Purpose: self-checking bench for dcbo_top
// Assumes: hold-off shortened to 3000 clocks
// Notes: filter output is predicted only while the estimate is held
`timescale 1ns/100ps
`include "dcbo_consts.vh"
module tb;
  reg clk_i, rst_n_i, rd, wr, stb, hold, i2s, dchk, fprev, pprev, mf, mb;
  reg [2:0] adr;
  reg [31:0] wd, q, rv;
  reg [23:0] sl, sr;
  wire [31:0] rdata;
  wire wreq, ostb, fco, bco, coe, ovn, ovoe, irq, bclk, fclk, fl, fr;
  wire [23:0] ol, orr;
  wire pin = ovoe ? 1'b0 : 1'b1;
  integer n_mismatch, n_checks, cyc, since, e, est_l, est_r, i, k;
  dcbo_top #(.TOUT_SS(24'h000BB8), .TOUT_DS(24'h0007D0), .TOUT_QS(24'h0003E8)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .dc_block_hold_i(hold), .smp_stb_i(stb), .smp_l_i(sl), .smp_r_i(sr), .out_stb_o(ostb),
    .out_l_o(ol), .out_r_o(orr), .frame_clock_i(fclk), .bit_clock_i(bclk),
    .frame_clock_o(fco), .bit_clock_o(bco), .clocks_oe_o(coe), .ovfl_n_o(ovn),
    .ovfl_oe_o(ovoe), .irq_o(irq));
  dcbo_host u_host (.i2s_i(i2s), .pin_i(pin), .bit_clock_o(bclk), .frame_clock_o(fclk),
    .flag_l_o(fl), .flag_r_o(fr));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task bus(input w, input [2:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      @(posedge clk_i);
      while (wreq !== 1'b0) @(posedge clk_i);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  function integer clip(input integer v);
    clip = v > 8388607 ? 8388607 : (v < -8388608 ? -8388608 : v);
  endfunction
  task smp(input [23:0] l, input [23:0] r, input ck);
    begin
      @(posedge clk_i);
      sl <= l;
      sr <= r;
      stb <= 1'b1;
      @(posedge clk_i);
      stb <= 1'b0;
      while (ostb !== 1'b1) @(posedge clk_i);
      if (ck) begin
        e = clip($signed(l) - est_l);
        chk("out_l", {8'h00, ol}, {8'h00, e[23:0]});
        e = clip($signed(r) - est_r);
        chk("out_r", {8'h00, orr}, {8'h00, e[23:0]});
      end
    end
  endtask
  // pin delay is timed from the frame edge as this clock sees it
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    fprev <= fclk;
    pprev <= pin;
    since <= (fclk !== fprev) ? 0 : since + 1;
    if (dchk && pin !== pprev && i2s) chk("i2s_dly", since >= 18 && since <= 32, 1);
    if (dchk && pin !== pprev && !i2s) chk("lj_dly", since >= 5 && since <= 16, 1);
    if (cyc == 70000) begin
      n_mismatch = n_mismatch + 1;
      close_out;
    end
  end
  initial begin
    {n_mismatch, n_checks, cyc, since, est_l, est_r} = 0;
    {rst_n_i, rd, wr, stb, i2s, dchk, fprev, adr, wd, sl, sr} = 0;
    hold = 1'b1;
    pprev = 1'b1;
    rv = $urandom(32'h000b1158);
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, 3'h7, 32'h0);
    chk("unmapped", q, 32'h0);
    for (k = 0; k < 3; k = k + 1) begin
      bus(1'b1, `DCBO_REG_CTRL, k << 3);
      bus(1'b0, `DCBO_REG_CTRL, 32'h0);
      chk("ctrl", q, k << 3);
    end
    bus(1'b1, `DCBO_REG_CTRL, 32'h0);
    $display("test regs done");
    for (k = 0; k < 2; k = k + 1) begin
      hold <= 1'b1;
      repeat (k ? 4 : 0) @(posedge clk_i);
      if (k) bus(1'b0, `DCBO_REG_DCL, 32'h0);
      est_l = k ? $signed(q[23:0]) : 0;
      if (k) bus(1'b0, `DCBO_REG_DCR, 32'h0);
      est_r = k ? $signed(q[23:0]) : 0;
      if (k) chk("est", est_l > 0 && est_l < 4194304 && est_r == est_l, 1);
      for (i = 0; i < 20; i = i + 1) begin
        rv = $urandom;
        smp(rv[23:0], rv[31:8], 1'b1);
      end
      if (k) bus(1'b0, `DCBO_REG_DCL, 32'h0);
      if (k) chk("est_hold", {8'h00, q[23:0]}, {8'h00, est_l[23:0]});
      if (!k) begin
        hold <= 1'b0;
        repeat (100) smp(24'h400000, 24'h400000, 1'b0);
        hold <= 1'b1;
      end
    end
    $display("test filter done");
    for (k = 0; k < 2; k = k + 1) begin
      i2s <= k[0];
      bus(1'b1, `DCBO_REG_CTRL, k << 1);
      dchk <= 1'b1;
      repeat (4000) @(posedge clk_i);
      smp(24'h800000, 24'h000000, 1'b0);
      repeat (2500) @(posedge clk_i);
      chk("flags", {fl, fr}, 2'b10);
      smp(24'h000000, 24'h800000, 1'b0);
      repeat (2500) @(posedge clk_i);
      chk("left_held", fl, 1);
      repeat (6000) @(posedge clk_i);
      chk("flags_off", {fl, fr}, 0);
      bus(1'b0, `DCBO_REG_STAT, 32'h0);
      chk("stat", q, 3);
      bus(1'b1, `DCBO_REG_MASK, 32'h3);
      repeat (2) @(posedge clk_i);
      chk("irq_on", irq, 1);
      bus(1'b1, `DCBO_REG_STAT, 32'h3);
      repeat (2) @(posedge clk_i);
      chk("irq_off", irq, 0);
      bus(1'b1, `DCBO_REG_MASK, 32'h0);
      $display("test overrange format %0d done", k);
    end
    dchk <= 1'b0;
    bus(1'b1, `DCBO_REG_CTRL, 32'h4);
    repeat (600) @(posedge clk_i);
    chk("clk_oe", coe, 1);
    mf = fco;
    while (fco === mf) @(posedge clk_i);
    {mf, mb, i} = {fco, bco, 32'h0};
    while (fco === mf) begin
      @(posedge clk_i);
      if (bco && !mb) i = i + 1;
      mb = bco;
    end
    chk("bits_half", i, 32);
    $display("test master done");
    close_out;
  end
endmodule // tb
